// ---- src/apc_pkg.sv ----
// ---------------------------------------------------------------
// shared constants for pll divider and calibration control
// ---------------------------------------------------------------
package apc_pkg;
   // timing
   localparam int CLK_PERIOD_NS = 10; // 100 mhz crystal-side clock
   localparam int CAL_TIME_NS = 2000; // oscillator settle window
   localparam int CAL_CYCLES = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CAL_W = $clog2(CAL_CYCLES + 1);
   // sizes
   localparam int NUM_CH = 12;
   localparam int NUM_PLL = 2;
   // byte offsets
   localparam logic [7:0] A_CTRL = 8'h00; // status sits at +4
   localparam logic [7:0] A_REFDIV = 8'h08;
   localparam logic [7:0] A_INT = 8'h10;
   localparam logic [7:0] A_NUML = 8'h18;
   localparam logic [7:0] A_NUMH = 8'h20;
   localparam logic [7:0] A_DEN = 8'h28;
   localparam logic [7:0] A_POST = 8'h30;
   localparam logic [7:0] A_CH_BASE = 8'h40;
   localparam logic [7:0] A_FR_BASE = 8'h80;
   // control fields
   localparam int C_EN = 0; // bits 1:0
   localparam int C_SRST = 2;
   localparam int C_DL = 3; // bits 4:3
   localparam int C_REF2 = 5;
   localparam int C_REF1 = 6;
   localparam int C_DLR = 7;
   // other fields
   localparam int RD_BYP = 5;
   localparam int RD_DBL = 6;
   localparam int DEN_SEL = 24;
   localparam int P1_D2 = 3;
   localparam int P2S = 8;
   localparam int CH_BYP = 12;
   localparam int CH_FEN = 13;
   localparam int CH_SRC = 14;
   localparam int CH_MUTE = 15;
   // write masks, reserved bits read zero
   localparam logic [31:0] M_CTRL = 32'h0000_00FF;
   localparam logic [31:0] M_REFDIV = 32'h0000_007F;
   localparam logic [31:0] M_INT = 32'h0000_0FFF;
   localparam logic [31:0] M_NUMH = 32'h0000_00FF;
   localparam logic [31:0] M_DEN = 32'h01FF_FFFF;
   localparam logic [31:0] M_POST = 32'h0000_01FF;
   localparam logic [31:0] M_CH = 32'h0000_FFFF;
   localparam logic [31:0] M_FR = 32'h000F_FFFF;
   // reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_0003;
   localparam logic [31:0] REFDIV_RST = 32'h0000_0020;
   localparam logic [31:0] INT_RST = 32'h0000_0064;
   localparam logic [31:0] DEN_RST = 32'h0100_0000;
   localparam logic [31:0] POST_RST = 32'h0000_0020;
   localparam logic [31:0] CH_RST = 32'h0000_8001;
   localparam logic [31:0] FR_RST = 32'h0000_0001;
   // channels with no frame-reference divider
   localparam logic [11:0] FRAME_EXEMPT = 12'h00C;
   // calibration sequencer states
   typedef enum logic [4:0] {
      S_IDLE = 5'h01,
      S_WAIT = 5'h02,
      S_CAL = 5'h04,
      S_LOCK = 5'h08,
      S_RUN = 5'h10
   } apc_cal_e;
endpackage

// ---- src/apc_top.sv ----
// How it works
// (RL1) second pll posts: primary 2-13, secondary 2-3
// (RL2) first pll post setting 1..8, 1 bypasses
// (RL3) first post: divide up to 8, optional /2
// (RL4) each channel: 12-bit divider or bypass
// (RL5) optional 20-bit frame divider, not outputs 2-3
// (RL6) feedback: 12-bit int, 40-bit num, selectable denominator
// (RL7) digital loop mode forces fixed 2^40 denominator
// (RL8) host picks 24-bit denominator when standalone
// (RL9) modulator dithers ratio every comparison event
// (RL10) digital loop drives numerator in loop mode
// (RL11) oscillator also feeds digital loop feedback path
// (RL12) 5-bit reference divider, bypass gives divide-one
// (RL13) doubler doubles the comparison event rate
// (RL14) host keeps fraction 0.125..0.875, avoids 0.5
// (RL15) first pll uses crystal reference in free-run
// (RL16) second pll reference: first oscillator or crystal
// (RL17) oscillators routable to loop and other pll
// (RL18) calibration autostarts after reset once crystal present
// (RL19) outputs muted until calibrated and locked, per output
// (RL20) enable rising edge recalibrates that pll only
// (RL21) both post clocks selectable by every output
// (RL22) host uses post one plus channel dividers
// (RL23) unmute only after calibration done and lock
//
// The address map and the Wishbone slave port were decided locally.
`timescale 1ns/100ps
module apc_top
   import apc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic xo_present_i,
   input wire logic xo_tick_i,
   input wire logic [1:0] osc_tick_i,
   input wire logic [1:0] lock_i,
   input wire logic [1:0][39:0] dl_num_i,
   output logic [1:0] ref_tick_o,
   output logic [1:0][12:0] fb_ratio_o,
   output logic [1:0] cal_active_o,
   output logic [1:0] dl_fb_tick_o,
   output logic dl_ref_tick_o,
   output logic [2:0] post_tick_o,
   output logic [11:0] out_tick_o,
   output logic [11:0] mute_o
);
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // byte-lane merge for wishbone writes
   function automatic logic [31:0] merge_f(input logic [31:0] old, input logic [31:0] d,
                                           input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = d[8*b +: 8];
         end
      end
      return r;
   endfunction

   // terminal count; a limit of zero acts as one
   function automatic logic hit_f(input logic [19:0] cnt, input logic [19:0] lim);
      return ({1'b0, cnt} + 21'h1) >= {1'b0, lim};
   endfunction

   // ---------------------------------------------------------------
   // register file and bus slave
   // ---------------------------------------------------------------
   logic [31:0] ctrl, next_ctrl; // enables, modes, routing
   logic [31:0] refdiv [2], next_refdiv [2]; // ref divider, doubler
   logic [31:0] fb_int [2], next_fb_int [2]; // feedback integer
   logic [31:0] numl [2], next_numl [2]; // numerator low word
   logic [31:0] numh [2], next_numh [2]; // numerator high byte
   logic [31:0] denominator_part [2], next_den [2]; // denominator and select
   logic [31:0] post, next_post; // post divider settings
   logic [31:0] chc [NUM_CH], next_chc [NUM_CH]; // channel config
   logic [31:0] frd [NUM_CH], next_frd [NUM_CH]; // frame divider
   logic [31:0] next_rdat;
   logic next_ack;
   logic [31:0] status; // live state for software
   apc_cal_e st [2]; // calibration state per pll
   logic p; // pll select from address bit 2
   logic [3:0] ch; // channel index from address
   logic ch_ok;

   always_comb begin
      for (int k = 0; k < 2; k++) begin
         status[k] = (st[k] == S_LOCK) || (st[k] == S_RUN);
      end
      status[3:2] = lock_i;
      status[15:4] = mute_o;
      status[31:16] = 16'h0000;
   end

   assign p = wb_adr_i[2];
   assign ch = wb_adr_i[5:2];
   assign ch_ok = ch < 4'(NUM_CH);

   // decode, byte lanes, unmapped reads give zero and still ack
   always_comb begin
      next_ctrl = ctrl;
      next_refdiv = refdiv;
      next_fb_int = fb_int;
      next_numl = numl;
      next_numh = numh;
      next_den = denominator_part;
      next_post = post;
      next_chc = chc;
      next_frd = frd;
      next_ctrl[C_SRST] = 1'b0; // soft reset self clears
      next_ack = 1'b0;
      next_rdat = 32'h0000_0000;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
         next_ack = 1'b1;
         case ({wb_adr_i[7:3], 3'b000})
            A_CTRL: begin
               next_rdat = p ? status : ctrl;
               if (wb_we_i && !p) begin
                  next_ctrl = merge_f(ctrl, wb_dat_i, wb_sel_i) & M_CTRL;
               end
            end
            A_REFDIV: begin
               next_rdat = refdiv[p];
               if (wb_we_i) begin
                  next_refdiv[p] = merge_f(refdiv[p], wb_dat_i, wb_sel_i) & M_REFDIV;
               end
            end
            A_INT: begin
               next_rdat = fb_int[p];
               if (wb_we_i) begin
                  next_fb_int[p] = merge_f(fb_int[p], wb_dat_i, wb_sel_i) & M_INT;
               end
            end
            A_NUML: begin
               next_rdat = numl[p];
               if (wb_we_i) begin
                  next_numl[p] = merge_f(numl[p], wb_dat_i, wb_sel_i);
               end
            end
            A_NUMH: begin
               next_rdat = numh[p];
               if (wb_we_i) begin
                  next_numh[p] = merge_f(numh[p], wb_dat_i, wb_sel_i) & M_NUMH;
               end
            end
            A_DEN: begin
               next_rdat = denominator_part[p];
               if (wb_we_i) begin
                  next_den[p] = merge_f(denominator_part[p], wb_dat_i, wb_sel_i) & M_DEN;
               end
            end
            A_POST: begin
               next_rdat = p ? 32'h0000_0000 : post;
               if (wb_we_i && !p) begin
                  next_post = merge_f(post, wb_dat_i, wb_sel_i) & M_POST;
               end
            end
            default: begin
               // channel blocks; holes above channel 11 are unmapped
               if (ch_ok && wb_adr_i[7:6] == A_CH_BASE[7:6]) begin
                  next_rdat = chc[ch];
                  if (wb_we_i) begin
                     next_chc[ch] = merge_f(chc[ch], wb_dat_i, wb_sel_i) & M_CH;
                  end
               end else if (ch_ok && wb_adr_i[7:6] == A_FR_BASE[7:6]) begin
                  next_rdat = frd[ch];
                  if (wb_we_i) begin
                     next_frd[ch] = merge_f(frd[ch], wb_dat_i, wb_sel_i) & M_FR;
                  end
               end
            end
         endcase
      end
   end

   // register stage for the bus group
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= CTRL_RST;
         post <= POST_RST;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         for (int k = 0; k < 2; k++) begin
            refdiv[k] <= REFDIV_RST;
            fb_int[k] <= INT_RST;
            numl[k] <= 32'h0000_0000;
            numh[k] <= 32'h0000_0000;
            denominator_part[k] <= DEN_RST;
         end
         for (int c = 0; c < NUM_CH; c++) begin
            chc[c] <= CH_RST;
            frd[c] <= FR_RST;
         end
      end else begin
         ctrl <= next_ctrl;
         post <= next_post;
         wb_ack_o <= next_ack;
         wb_dat_o <= next_rdat;
         refdiv <= next_refdiv;
         fb_int <= next_fb_int;
         numl <= next_numl;
         numh <= next_numh;
         denominator_part <= next_den;
         chc <= next_chc;
         frd <= next_frd;
      end
   end

   // ---------------------------------------------------------------
   // calibration sequencer, one per pll
   // ---------------------------------------------------------------
   apc_cal_e next_st [2];
   logic [CAL_W-1:0] ccnt [2], next_ccnt [2]; // calibration timer
   logic [1:0] en_q, next_en_q; // enable history for edge detect
   logic [1:0] next_calact;

   // reset or soft reset restarts, enable rise restarts one pll
   always_comb begin
      for (int k = 0; k < 2; k++) begin
         next_st[k] = st[k];
         next_ccnt[k] = ccnt[k];
         next_en_q[k] = ctrl[C_EN + k];
         if (!ctrl[C_EN + k]) begin
            next_st[k] = S_IDLE;
         end else if ((!en_q[k]) || ctrl[C_SRST]) begin
            next_st[k] = S_WAIT; // RL20
         end else begin
            unique case (st[k])
               S_IDLE: next_st[k] = S_IDLE;
               S_WAIT: begin
                  // calibrating on a dead crystal would fail
                  if (xo_present_i) begin
                     next_st[k] = S_CAL; // RL18
                     next_ccnt[k] = '0;
                  end
               end
               S_CAL: begin
                  if (ccnt[k] == CAL_W'(CAL_CYCLES - 1)) begin
                     next_st[k] = S_LOCK;
                  end else begin
                     next_ccnt[k] = ccnt[k] + 1'b1;
                  end
               end
               S_LOCK: if (lock_i[k]) next_st[k] = S_RUN; // RL23
               S_RUN: if (!lock_i[k]) next_st[k] = S_LOCK; // RL19
            endcase
         end
         next_calact[k] = next_st[k] == S_CAL;
      end
   end

   // start in wait so power-up calibrates without software
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st[0] <= S_WAIT; // RL18
         st[1] <= S_WAIT;
         ccnt[0] <= '0;
         ccnt[1] <= '0;
         en_q <= CTRL_RST[1:0];
         cal_active_o <= 2'b00;
      end else begin
         st <= next_st;
         ccnt <= next_ccnt;
         en_q <= next_en_q;
         cal_active_o <= next_calact;
      end
   end

   // ---------------------------------------------------------------
   // reference path and fractional modulator
   // ---------------------------------------------------------------
   logic [1:0] srcq, next_srcq; // delayed ref edge for doubler
   logic [4:0] rcnt [2], next_rcnt [2]; // reference divider count
   logic [39:0] facc [2], next_facc [2]; // modulator accumulator
   logic [1:0] rhit; // comparison event this cycle
   logic [1:0] next_rtick, next_dlfb;
   logic [1:0][12:0] next_ratio;
   logic next_dlref;

   // a programmable numerator above the denominator saturates the
   // carry rate at one per event; keep it below the denominator
   always_comb begin
      logic src, ev, dl, carry;
      logic [19:0] rlim;
      logic [39:0] num;
      logic [40:0] sum, dmod;
      src = 1'b0;
      ev = 1'b0;
      dl = 1'b0;
      carry = 1'b0;
      rlim = 20'h0;
      num = 40'h0;
      sum = 41'h0;
      dmod = 41'h0;
      for (int k = 0; k < 2; k++) begin
         if (k == 0) begin
            src = ctrl[C_REF1] ? osc_tick_i[1] : xo_tick_i; // RL15 RL17
         end else begin
            src = ctrl[C_REF2] ? osc_tick_i[0] : xo_tick_i; // RL16
         end
         next_srcq[k] = src;
         ev = src || (refdiv[k][RD_DBL] && srcq[k]); // RL13
         rlim = refdiv[k][RD_BYP] ? 20'h1 : 20'(refdiv[k][4:0]) + 20'h1; // RL12
         rhit[k] = (st[k] != S_IDLE) && ev && hit_f(20'(rcnt[k]), rlim);
         next_rcnt[k] = rcnt[k];
         if (st[k] == S_IDLE) begin
            next_rcnt[k] = 5'h00;
         end else if (ev) begin
            next_rcnt[k] = rhit[k] ? 5'h00 : rcnt[k] + 5'h01;
         end
         next_rtick[k] = rhit[k];
         dl = ctrl[C_DL + k];
         num = dl ? dl_num_i[k] : {numh[k][7:0], numl[k]}; // RL10
         next_facc[k] = facc[k];
         next_ratio[k] = fb_ratio_o[k];
         if (rhit[k]) begin
            if (dl || !denominator_part[k][DEN_SEL]) begin
               sum = {1'b0, facc[k]} + {1'b0, num}; // RL7
               carry = sum[40];
               next_facc[k] = sum[39:0];
            end else begin
               dmod = (denominator_part[k][23:0] == 24'h0) ? 41'h0_0100_0000 : {17'h0, denominator_part[k][23:0]};
               sum = {1'b0, facc[k]} + {17'h0, num[23:0]}; // RL6
               carry = sum >= dmod;
               next_facc[k] = carry ? 40'(sum - dmod) : sum[39:0];
            end
            next_ratio[k] = {1'b0, fb_int[k][11:0]} + {12'h000, carry}; // RL9
         end
         next_dlfb[k] = dl && (st[k] != S_IDLE) && osc_tick_i[k]; // RL11
      end
      next_dlref = ctrl[C_DLR] ? osc_tick_i[1] : osc_tick_i[0]; // RL17
   end

   // register stage for the reference group
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         srcq <= 2'b00;
         rcnt[0] <= 5'h00;
         rcnt[1] <= 5'h00;
         facc[0] <= 40'h0;
         facc[1] <= 40'h0;
         ref_tick_o <= 2'b00;
         fb_ratio_o <= '0;
         dl_fb_tick_o <= 2'b00;
         dl_ref_tick_o <= 1'b0;
      end else begin
         srcq <= next_srcq;
         rcnt <= next_rcnt;
         facc <= next_facc;
         ref_tick_o <= next_rtick;
         fb_ratio_o <= next_ratio;
         dl_fb_tick_o <= next_dlfb;
         dl_ref_tick_o <= next_dlref;
      end
   end

   // ---------------------------------------------------------------
   // post dividers and output channel dividers
   // ---------------------------------------------------------------
   logic [3:0] pcnt [3], next_pcnt [3]; // post divider counts
   logic [4:0] pr [3]; // effective post ratios
   logic [11:0] dcnt [NUM_CH], next_dcnt [NUM_CH]; // 12-bit stage
   logic [19:0] fcnt [NUM_CH], next_fcnt [NUM_CH]; // frame stage
   logic [2:0] next_ptick;
   logic [11:0] next_otick, next_mute;

   // post ratios, then channels on the registered post ticks
   always_comb begin
      logic sev, c1, c2, fuse, muted, pev;
      logic [3:0] p1;
      sev = 1'b0;
      c1 = 1'b0;
      c2 = 1'b0;
      fuse = 1'b0;
      muted = 1'b0;
      pev = 1'b0;
      p1 = 4'(post[2:0]) + 4'h1;
      pr[0] = (post[2:0] == 3'h0) ? 5'h01 : 5'(p1) << post[P1_D2]; // RL2 RL3
      if (post[7:4] < 4'h2) begin
         pr[1] = 5'h02; // RL1
      end else if (post[7:4] > 4'hD) begin
         pr[1] = 5'h0D;
      end else begin
         pr[1] = 5'(post[7:4]);
      end
      pr[2] = post[P2S] ? 5'h03 : 5'h02; // RL1
      for (int k = 0; k < 3; k++) begin
         pev = (k == 0) ? osc_tick_i[0] : osc_tick_i[1];
         next_ptick[k] = pev && hit_f(20'(pcnt[k]), 20'(pr[k]));
         next_pcnt[k] = pcnt[k];
         if (pev) begin
            next_pcnt[k] = next_ptick[k] ? 4'h0 : pcnt[k] + 4'h1;
         end
      end
      for (int c = 0; c < NUM_CH; c++) begin
         sev = chc[c][CH_SRC] ? post_tick_o[1] : post_tick_o[0]; // RL21
         c1 = sev && (chc[c][CH_BYP] || hit_f(20'(dcnt[c]), 20'(chc[c][11:0]))); // RL4
         next_dcnt[c] = dcnt[c];
         if (sev && !chc[c][CH_BYP]) begin
            next_dcnt[c] = c1 ? 12'h000 : dcnt[c] + 12'h001;
         end
         fuse = chc[c][CH_FEN] && !FRAME_EXEMPT[c]; // RL5
         c2 = c1 && (!fuse || hit_f(fcnt[c], frd[c][19:0]));
         next_fcnt[c] = fcnt[c];
         if (!fuse) begin
            next_fcnt[c] = 20'h0;
         end else if (c1) begin
            next_fcnt[c] = c2 ? 20'h0 : fcnt[c] + 20'h1;
         end
         // mute enable off lets an output run before lock
         muted = chc[c][CH_MUTE] && (st[chc[c][CH_SRC]] != S_RUN); // RL19 RL23
         next_mute[c] = muted;
         next_otick[c] = c2 && !muted;
      end
   end

   // register stage for the divider group
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int k = 0; k < 3; k++) begin
            pcnt[k] <= 4'h0;
         end
         for (int c = 0; c < NUM_CH; c++) begin
            dcnt[c] <= 12'h000;
            fcnt[c] <= 20'h0;
         end
         post_tick_o <= 3'b000;
         out_tick_o <= 12'h000;
         mute_o <= 12'hFFF;
      end else begin
         pcnt <= next_pcnt;
         dcnt <= next_dcnt;
         fcnt <= next_fcnt;
         post_tick_o <= next_ptick;
         out_tick_o <= next_otick;
         mute_o <= next_mute;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_post1_bypass;
      osc_tick_i[0] && post[2:0] == 3'h0 |=> post_tick_o[0];
   endproperty
   a_post1_bypass: assert property (p_post1_bypass) else $error("post bypass lost tick"); // RL2

   property p_post1_spacing;
      post_tick_o[0] && post[2:0] == 3'h1 && $stable(post) |=> !post_tick_o[0];
   endproperty
   a_post1_spacing: assert property (p_post1_spacing) else $error("post ratio two broken"); // RL3

   property p_post2_range;
      pr[1] >= 5'h02 && pr[1] <= 5'h0D && pr[2] >= 5'h02 && pr[2] <= 5'h03;
   endproperty
   a_post2_range: assert property (p_post2_range) else $error("second post out of range"); // RL1

   property p_ch_bypass;
      post_tick_o[0] && !chc[0][CH_SRC] && chc[0][CH_BYP] && !chc[0][CH_FEN] && !mute_o[0]
         && $stable(chc[0]) |=> out_tick_o[0] || mute_o[0];
   endproperty
   a_ch_bypass: assert property (p_ch_bypass) else $error("channel bypass lost tick"); // RL4

   property p_frame_exempt;
      fcnt[2] == 20'h0 && fcnt[3] == 20'h0;
   endproperty
   a_frame_exempt: assert property (p_frame_exempt) else $error("frame stage on exempt pair"); // RL5

   property p_ref_double;
      xo_tick_i && !ctrl[C_REF1] && refdiv[0][RD_DBL] && refdiv[0][RD_BYP]
         && st[0] != S_IDLE && $stable(st[0]) ##1 $stable(st[0]) |-> ref_tick_o[0] [*2];
   endproperty
   a_ref_double: assert property (p_ref_double) else $error("doubler missed event"); // RL13

   property p_xo_start;
      st[0] == S_WAIT && xo_present_i && ctrl[C_EN] && en_q[0] && !ctrl[C_SRST]
         |=> st[0] == S_CAL ##1 cal_active_o[0];
   endproperty
   a_xo_start: assert property (p_xo_start) else $error("calibration did not start"); // RL18

   property p_cal_length;
      $rose(st[0] == S_CAL) |-> (st[0] == S_CAL || !ctrl[C_EN] || ctrl[C_SRST]) [*8];
   endproperty
   a_cal_length: assert property (p_cal_length) else $error("calibration cut short"); // RL18

   property p_unmute;
      $fell(mute_o[0]) |-> $past(st[chc[0][CH_SRC]] == S_RUN || !chc[0][CH_MUTE]);
   endproperty
   a_unmute: assert property (p_unmute) else $error("unmuted before lock"); // RL23 RL19

   property p_enable_rise;
      $rose(ctrl[C_EN + 1]) |=> st[1] == S_WAIT;
   endproperty
   a_enable_rise: assert property (p_enable_rise) else $error("enable edge ignored"); // RL20

   property p_dl_fixed;
      rhit[1] && ctrl[C_DL + 1] |=> facc[1] == 40'($past(facc[1]) + $past(dl_num_i[1]));
   endproperty
   a_dl_fixed: assert property (p_dl_fixed) else $error("loop mode not on fixed modulus"); // RL7 RL10

   c_unmute: cover property ($fell(mute_o[0]));
   c_cal_done: cover property (st[1] == S_CAL ##1 st[1] == S_LOCK);
   c_frame_tick: cover property (out_tick_o[4] && chc[4][CH_FEN]);
   c_dither: cover property (ref_tick_o[0] ##1 $changed(fb_ratio_o[0]));
endmodule // apc_top

// ---- tb/apc_loop_model.sv ----
`timescale 1ns/100ps
// ---------------------------------------------------------------
// digital loop and analog stand-in
// ---------------------------------------------------------------
module apc_loop_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [1:0] cal_active_i,
   output logic xo_tick_o,
   output logic [1:0] osc_tick_o,
   output logic [1:0] lock_o,
   output logic [1:0][39:0] dl_num_o
);
   logic [1:0] was_cal; // calibration level one cycle back
   logic [1:0][2:0] settle; // cycles since calibration ended
   // ticks every cycle keep the counts short; lock follows calibration
   always_ff @(posedge clk_i) begin
      xo_tick_o <= !rst_i;
      osc_tick_o <= {2{!rst_i}};
      dl_num_o <= {40'h60_0000_0000, 40'h40_0000_0000};
      for (int k = 0; k < 2; k++) begin
         was_cal[k] <= cal_active_i[k];
         // no lock while calibrating, a few cycles to settle after
         if (rst_i || cal_active_i[k]) settle[k] <= 3'h0;
         else if ((was_cal[k] || settle[k] != 3'h0) && settle[k] != 3'h7) settle[k] <= settle[k] + 3'h1;
         lock_o[k] <= (settle[k] >= 3'h4);
      end
   end
endmodule // apc_loop_model

// ---- tb/apc_top_tb_top.sv ----
`timescale 1ns/100ps
module apc_top_tb_top;
   import apc_pkg::*;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, xo_present = 0, xo_tick, ack;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0, rdat, q;
   logic [1:0] osc_tick, lock, ref_tick, cal_act, dl_fb;
   logic [1:0][12:0] ratio; // feedback ratio per pll
   logic [2:0] post_t; // post divider ticks
   logic dl_ref; // loop reference tick
   wire [16:0] tk; // every tick that a gap is measured on
   logic [1:0][39:0] dl_num;
   logic [11:0] out_tick, mute;
   int n_mismatch = 0, n_tests = 0, k;
   apc_top apc_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hF), .wb_dat_o(rdat),
      .wb_ack_o(ack), .xo_present_i(xo_present), .xo_tick_i(xo_tick), .osc_tick_i(osc_tick),
      .lock_i(lock), .dl_num_i(dl_num), .ref_tick_o(ref_tick), .fb_ratio_o(ratio),
      .cal_active_o(cal_act), .dl_fb_tick_o(dl_fb), .dl_ref_tick_o(dl_ref), .post_tick_o(post_t),
      .out_tick_o(out_tick), .mute_o(mute));
   apc_loop_model apc_loop_model_i (.clk_i(clk_i), .rst_i(rst_i), .cal_active_i(cal_act),
      .xo_tick_o(xo_tick), .osc_tick_o(osc_tick), .lock_o(lock), .dl_num_o(dl_num));
   assign tk = {out_tick, post_t, ref_tick};
   initial forever #5 clk_i = !clk_i;
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // one classic cycle, held until ack is sampled
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
      k = 0;
      do begin @(posedge clk_i); k++; end while (ack !== 1'b1 && k < 50);
      q = rdat;
      cyc <= 0; stb <= 0;
      if (k >= 50) chk("ack", 0, 1);
   endtask
   // bounded wait for a calibration level
   task wait_cal(input int p, input logic lvl);
      k = 0;
      while (cal_act[p] !== lvl && k < 400) begin @(posedge clk_i); k++; end
      chk("cal wait", k < 400, 1);
   endtask
   task t_regs;
      bus(0, A_CTRL, 0); chk("ctrl rst", q, CTRL_RST);
      bus(0, A_REFDIV, 0); chk("refdiv rst", q, REFDIV_RST);
      bus(0, A_CH_BASE, 0); chk("ch rst", q, CH_RST);
      bus(1, A_INT, 32'hFFFF_FFFF); bus(0, A_INT, 0); chk("int", q, M_INT);
      bus(1, A_DEN, 32'hFFFF_FFFF); bus(0, A_DEN, 0); chk("den", q, M_DEN);
      bus(1, 8'hF0, 32'h1234_5678); bus(0, 8'hF0, 0); chk("unmapped", q, 0);
      chk("mute rst", mute, 12'hFFF);
      $display("regs done");
   endtask
   task t_cal;
      repeat (20) @(posedge clk_i);
      chk("no cal w/o xo", cal_act, 0);
      xo_present <= 1;
      wait_cal(0, 1);
      chk("muted in cal", mute, 12'hFFF);
      wait_cal(0, 0);
      repeat (20) @(posedge clk_i);
      chk("unmuted", mute, 12'h000);
      bus(0, A_CTRL + 8'h04, 0); chk("status", q, 32'h0000_000F);
      $display("cal done");
   endtask
   // cycles from one tick of a watched bit to the next
   task gap(input int i);
      @(posedge clk_i iff tk[i] === 1'b1);
      k = 0;
      do begin @(posedge clk_i); k++; end while (tk[i] !== 1'b1 && k < 20);
   endtask
   // carries of one pll's modulator over eight clock cycles
   task ones(input int p);
      k = 0;
      repeat (8) begin @(posedge clk_i); k += int'(ratio[p] === 13'h065); end
   endtask
   task t_refdiv;
      bus(1, A_REFDIV, 32'h0000_0003);
      gap(0); chk("ref gap", k, 4);
      bus(1, A_REFDIV, 32'h0000_0060);
      gap(0); chk("ref doubled", k, 1);
      $display("refdiv done");
   endtask
   // post ratios, channel divider and bypass, then post one plus dividers
   task t_div;
      bus(1, A_POST, 32'h0000_01E1);
      bus(1, A_CH_BASE + 8'h08, 32'h0000_8003);
      bus(1, A_CH_BASE, 32'h0000_1000);
      gap(2); chk("post two", k, 2);
      gap(3); chk("primary clamp", k, 13);
      gap(4); chk("secondary", k, 3);
      gap(7); chk("ch div", k, 6);
      gap(5); chk("ch bypass", k, 2);
      bus(1, A_POST, 32'h0000_0000);
      gap(7); chk("ch div post one", k, 3);
      $display("div done");
   endtask
   // fraction 3/8 on the programmable modulus, then in loop mode
   task t_frac;
      bus(1, A_DEN + 8'h04, 32'h0100_0008);
      bus(1, A_NUML + 8'h04, 32'h0000_0003);
      ones(1); chk("carries", k, 3);
      bus(1, A_CTRL, 32'h0000_0013);
      ones(1); chk("loop carries", k, 3);
      chk("loop fb", dl_fb, 2'b10);
      chk("loop ref", dl_ref, 1);
      $display("frac done");
   endtask
   task t_recal;
      bus(1, A_CH_BASE + 8'h04, 32'h0000_C001);
      bus(1, A_CTRL, 32'h0000_0001); bus(1, A_CTRL, 32'h0000_0003);
      wait_cal(1, 1);
      chk("pll0 stays", cal_act[0], 0);
      chk("per out mute", mute[1:0], 2'b10);
      wait_cal(1, 0);
      repeat (20) @(posedge clk_i);
      chk("pll1 unmuted", mute[1], 0);
      $display("recal done");
   endtask
   task close_out;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #20000;
      n_mismatch++;
      close_out();
   end
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 0;
      t_regs(); t_cal(); t_refdiv(); t_recal(); t_div(); t_frac();
      close_out();
   end
endmodule // apc_top_tb_top
